// ==== hdl/gas_alarm_defines.svh ====
`ifndef GAS_ALARM_DEFINES_SVH
`define GAS_ALARM_DEFINES_SVH

`define NUM_DET 4
`define NUM_LVL 3
`define MEAS_W 12
`define NUM_REL 4

// register byte offsets
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_MODULE 12'h008
`define OFF_MEAS_BASE 12'h040
`define OFF_UNDER_BASE 12'h080
`define OFF_LVL_BASE 12'h100
`define OFF_RELMAP_BASE 12'h200

// control fields
`define CTRL_BUZ_DIS 0
`define CTRL_LINES 1
`define CTRL_BRIDGE 2
`define CTRL_RESET 32'h0000_0000

// level config fields
`define LVL_THR_LSB 0
`define LVL_FALLING 16
`define LVL_INST_EN 17
`define LVL_AVG_EN 18
`define LVL_HYST_LSB 19
`define LVL_MANUAL 21
`define LVL_RESET 32'h0002_0fff

// range limits and averaging
`define FULL_SCALE 12'hfff
`define HYST_STEP 12'h029
`define AVG_SHIFT 4
`define AVG_MIN_MIN 15
`define AVG_MAX_MIN 480

`define MAX_MOD_ONE 5
`define MAX_MOD_TWO 10
`define MOD_ADDR_MAX 6'h20
`define ANALOG_SPAN 6'h08

// buzzer cadence, in clock cycles
`define CLK_HZ 25000000
`define BUZ_BASE_MS 400
`define BUZ_BASE_CYC ((`CLK_HZ / 1000) * `BUZ_BASE_MS)

`endif

// ==== hdl/gas_alarm_pkg.sv ====
package gas_alarm_pkg;
    typedef enum logic [2:0] {
        AL_IDLE = 3'b001,
        AL_ACTIVE = 3'b010,
        AL_ACKED = 3'b100
    } ack_state_e;
endpackage : gas_alarm_pkg

// ==== hdl/alarm_level_n.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "gas_alarm_defines.svh"
module alarm_level_n
    import gas_alarm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic [11:0] meas,
    input wire logic [11:0] avg,
    input wire logic [31:0] cfg,
    input wire logic ack,
    output logic relay_norm,
    output logic relay_buz,
    output logic ind_on,
    output logic ind_blink,
    output logic buz_req
);
    typedef struct packed {
        ack_state_e st;
        logic cond;
        logic buz;
    } lvl_s;
    lvl_s q, next_q;
    logic [11:0] thr, hyst, clr_thr;
    logic falling, manual, hit_i, hit_a, hit, clear_i, clear_a, next_cond;

    always_comb begin
        thr = cfg[`LVL_THR_LSB +: 12];
        falling = cfg[`LVL_FALLING];
        manual = cfg[`LVL_MANUAL];
        hyst = 12'(`HYST_STEP * cfg[`LVL_HYST_LSB +: 2]);
        clr_thr = falling ? 12'(thr + hyst) : 12'(thr - hyst);
        // rising or falling comparison on sample and average
        hit_i = falling ? (meas <= thr) : (meas >= thr);
        hit_a = falling ? (avg <= thr) : (avg >= thr);
        clear_i = falling ? (meas > clr_thr) : (meas < clr_thr);
        clear_a = falling ? (avg > clr_thr) : (avg < clr_thr);
        hit = (cfg[`LVL_INST_EN] & hit_i) | (cfg[`LVL_AVG_EN] & hit_a);
        next_cond = q.cond ? !((!cfg[`LVL_INST_EN] | clear_i) &
                               (!cfg[`LVL_AVG_EN] | clear_a)) & (|cfg[18:17])
                           : hit;
        next_q = q;
        next_q.cond = next_cond;
        case (q.st)
            AL_IDLE: begin
                if (next_cond) begin
                    next_q.st = AL_ACTIVE;
                    next_q.buz = 1'b1;
                end
            end
            AL_ACTIVE: begin
                if (ack) begin
                    next_q.buz = 1'b0;
                    next_q.st = q.cond ? AL_ACKED : AL_IDLE;
                end else if (!q.cond && !manual) begin
                    next_q.st = AL_IDLE;
                end
            end
            AL_ACKED: begin
                if (!q.cond) next_q.st = AL_IDLE;
            end
            default: next_q.st = AL_IDLE;
        endcase
        if (q.st == AL_IDLE && ack) next_q.buz = 1'b0;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '{st: AL_IDLE, cond: 1'b0, buz: 1'b0};
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign relay_norm = q.st != AL_IDLE;
    assign relay_buz = q.st == AL_ACTIVE;
    assign ind_on = q.st != AL_IDLE;
    assign ind_blink = q.st == AL_ACTIVE && manual;
    assign buz_req = q.buz;

    a_ack_releases: assert property (@(posedge clk) disable iff (!rst_b)
        ce && ack && q.st == AL_ACTIVE |=> !relay_buz && !buz_req)
        else $error("ack left resettable relay or buzzer on");
    a_auto_clear: assert property (@(posedge clk) disable iff (!rst_b)
        ce && !manual && !q.cond && q.st != AL_IDLE |=> !relay_norm)
        else $error("auto mode relay held after clear");
    a_manual_hold: assert property (@(posedge clk) disable iff (!rst_b)
        ce && manual && q.st == AL_ACTIVE && !ack |=> relay_norm)
        else $error("manual alarm released without ack");
endmodule : alarm_level_n
`default_nettype wire

// ==== hdl/gas_alarm_ack_manager.sv ====
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "gas_alarm_defines.svh"
module gas_alarm_ack_manager
    import gas_alarm_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic reset_key,
    input wire logic [`NUM_DET-1:0] det_fail,
    output logic fault_relay,
    output logic buzzer,
    output logic [`NUM_REL-1:0] alarm_relay,
    output logic [`NUM_DET-1:0] over_range_alarm,
    output logic [`NUM_DET-1:0] under_range_alarm,
    output logic [`NUM_DET-1:0] no_ambiguity_alarm,
    output logic [`NUM_LVL-1:0] zone_ind_on,
    output logic [`NUM_LVL-1:0] zone_ind_blink
);
    localparam int NE = `NUM_DET * `NUM_LVL;
    localparam int MOD_W = 32;

    typedef struct packed {
        logic [31:0] ctrl;
        logic [`NUM_DET-1:0][11:0] meas;
        logic [`NUM_DET-1:0][11:0] avg;
        logic [`NUM_DET-1:0][11:0] under;
        logic [`NUM_DET-1:0] flam;
        logic [NE-1:0][21:0] lvl;
        logic [`NUM_REL-1:0][NE+2:0] relmap;
        logic [`NUM_REL-1:0] relbuz;
        logic [MOD_W-1:0] mod;
        logic [2:0] key;
        logic [23:0] cad;
        logic [31:0] rdata;
        logic [`NUM_DET-1:0] nam;
    } top_s;
    top_s q, next_q;

    logic ack, wr, rd, any_fail, cfg_err;
    logic [NE-1:0] rn, rb, ion, iblk, bz;
    logic [`NUM_DET-1:0] ovr, und;
    logic [5:0] mod_cnt;
    logic [5:0] span_cnt;
    logic [23:0] period;
    logic [1:0] top_lvl;

    // third stage compared with second, never the first stage
    assign ack = ce & q.key[1] & ~q.key[2];

    genvar g;
    generate
        for (g = 0; g < NE; g++) begin : g_lvl
            alarm_level_n u_lvl (
                .clk(clk),
                .rst_b(rst_b),
                .ce(ce),
                .meas(q.meas[g / `NUM_LVL]),
                .avg(q.avg[g / `NUM_LVL]),
                .cfg({10'h000, q.lvl[g]}),
                .ack(ack),
                .relay_norm(rn[g]),
                .relay_buz(rb[g]),
                .ind_on(ion[g]),
                .ind_blink(iblk[g]),
                .buz_req(bz[g])
            );
        end
    endgenerate

    always_comb begin
        for (int d = 0; d < `NUM_DET; d++) begin
            ovr[d] = q.meas[d] == `FULL_SCALE;
            und[d] = q.meas[d] <= q.under[d];
        end
        mod_cnt = '0;
        span_cnt = '0;
        for (int m = 0; m < MOD_W; m++) begin
            // six bits so that a full 32-module mask cannot wrap to zero
            mod_cnt = mod_cnt + 6'(q.mod[m]);
        end
        // with control bit 3 set, modules at positions 0, 8, 16 and 24 reserve eight slots each
        for (int m = 0; m < MOD_W; m += 8) begin
            if (q.mod[m] && q.ctrl[3]) span_cnt = span_cnt + `ANALOG_SPAN;
        end
        cfg_err = (q.ctrl[`CTRL_BRIDGE] && mod_cnt != 6'h00) ||
            (!q.ctrl[`CTRL_LINES] && mod_cnt > 6'(`MAX_MOD_ONE)) ||
            (q.ctrl[`CTRL_LINES] && mod_cnt > 6'(`MAX_MOD_TWO)) ||
            (span_cnt > `MOD_ADDR_MAX);
        any_fail = (|det_fail) | (|q.nam) | cfg_err;
    end

    always_comb begin
        top_lvl = 2'd0;
        for (int e = 0; e < NE; e++) begin
            if (bz[e] && 2'(e % `NUM_LVL) >= top_lvl) top_lvl = 2'(e % 3);
        end
        // higher level halves the pulse period
        period = 24'(`BUZ_BASE_CYC) >> top_lvl;
    end

    assign wr = psel & penable & pwrite & ce;
    assign rd = psel & ~penable & ~pwrite;

    always_comb begin
        next_q = q;
        next_q.key = {q.key[1:0], reset_key};
        next_q.cad = (q.cad >= period - 24'h1) ? 24'h0 : q.cad + 24'h1;
        for (int d = 0; d < `NUM_DET; d++) begin
            // no-ambiguity latch cleared only once reading falls back
            if (q.flam[d] && ovr[d]) next_q.nam[d] = 1'b1;
            else if (!ovr[d]) next_q.nam[d] = 1'b0;
            // exponential moving average; window set by shift
            next_q.avg[d] = 12'(q.avg[d] - (q.avg[d] >> `AVG_SHIFT)
                + (q.meas[d] >> `AVG_SHIFT));
        end
        if (wr) begin
            if (paddr == `OFF_CTRL) next_q.ctrl = pwdata;
            if (paddr == `OFF_MODULE) next_q.mod = pwdata;
            for (int d = 0; d < `NUM_DET; d++) begin
                if (paddr == `OFF_MEAS_BASE + 12'(4 * d)) begin
                    next_q.meas[d] = pwdata[11:0];
                    next_q.flam[d] = pwdata[31];
                end
                if (paddr == `OFF_UNDER_BASE + 12'(4 * d))
                    next_q.under[d] = pwdata[11:0];
            end
            for (int e = 0; e < NE; e++) begin
                if (paddr == `OFF_LVL_BASE + 12'(4 * e))
                    next_q.lvl[e] = pwdata[21:0];
            end
            for (int r = 0; r < `NUM_REL; r++) begin
                if (paddr == `OFF_RELMAP_BASE + 12'(4 * r)) begin
                    next_q.relmap[r] = pwdata[NE+2:0];
                    next_q.relbuz[r] = pwdata[31];
                end
            end
        end
        next_q.rdata = 32'h0;
        if (rd) begin
            case (paddr)
                `OFF_CTRL: next_q.rdata = q.ctrl;
                `OFF_STATUS: next_q.rdata = {16'h0, 1'b0, cfg_err,
                    2'b00, ~any_fail, 11'(ion)};
                `OFF_MODULE: next_q.rdata = q.mod;
                default: begin
                    // every setup register reads back for the setup tool
                    for (int d = 0; d < `NUM_DET; d++) begin
                        if (paddr == `OFF_MEAS_BASE + 12'(4 * d))
                            next_q.rdata = {q.flam[d], 19'h0, q.meas[d]};
                        if (paddr == `OFF_UNDER_BASE + 12'(4 * d))
                            next_q.rdata = {20'h0, q.under[d]};
                    end
                    for (int e = 0; e < NE; e++)
                        if (paddr == `OFF_LVL_BASE + 12'(4 * e))
                            next_q.rdata = {10'h0, q.lvl[e]};
                    for (int r = 0; r < `NUM_REL; r++)
                        if (paddr == `OFF_RELMAP_BASE + 12'(4 * r))
                            next_q.rdata = {q.relbuz[r], 16'h0, q.relmap[r]};
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            q <= '0;
            for (int e = 0; e < NE; e++) q.lvl[e] <= 22'(`LVL_RESET);
        end else if (ce) begin
            q <= next_q;
        end
    end

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign prdata = q.rdata;

    always_comb begin
        fault_relay = ~any_fail;
        for (int r = 0; r < `NUM_REL; r++) begin
            // buzzer-mode relays follow the resettable output
            alarm_relay[r] = |(q.relmap[r][NE-1:0] & (q.relbuz[r] ? rb : rn))
                | (q.relmap[r][NE] & |ovr)
                | (q.relmap[r][NE+1] & |und)
                | (q.relmap[r][NE+2] & any_fail);
        end
        for (int l = 0; l < `NUM_LVL; l++) begin
            zone_ind_on[l] = 1'b0;
            zone_ind_blink[l] = 1'b0;
            for (int d = 0; d < `NUM_DET; d++) begin
                zone_ind_on[l] |= ion[d * `NUM_LVL + l] & !iblk[d*3+l];
                zone_ind_blink[l] |= iblk[d * `NUM_LVL + l];
            end
        end
        over_range_alarm = ovr;
        under_range_alarm = und;
        no_ambiguity_alarm = q.nam;
        // steady tone on fault, pulsed tone on alarm
        buzzer = !q.ctrl[`CTRL_BUZ_DIS] && (any_fail ||
            (|bz && q.cad < (period >> 1)));
    end

    a_fault_relay: assert property (@(posedge clk) disable iff (!rst_b)
        |det_fail |-> !fault_relay)
        else $error("fault relay energised during failure");
    a_buzzer_off: assert property (@(posedge clk) disable iff (!rst_b)
        q.ctrl[`CTRL_BUZ_DIS] |-> !buzzer)
        else $error("buzzer sounded while disabled");
    a_under_range: assert property (@(posedge clk) disable iff (!rst_b)
        under_range_alarm[0] == (q.meas[0] <= q.under[0]))
        else $error("under-range flag mismatch");
    a_key_pulse: assert property (@(posedge clk) disable iff (!rst_b)
        ack |=> !ack)
        else $error("reset key gave more than one pulse");
    a_bridge_mods: assert property (@(posedge clk) disable iff (!rst_b)
        q.ctrl[`CTRL_BRIDGE] && q.mod != '0 |-> !fault_relay)
        else $error("modules accepted on bridge variant");
    c_ack: cover property (@(posedge clk) ack && |bz);
    c_blink: cover property (@(posedge clk) |zone_ind_blink);
    c_fault: cover property (@(posedge clk) !fault_relay);
    c_manual_ack: cover property (@(posedge clk) ack && |iblk);
    c_cfg_err: cover property (@(posedge clk) cfg_err);

    a_fault_free: assert property (@(posedge clk) disable iff (!rst_b)
        !any_fail |-> fault_relay)
        else $error("fault relay released with no failure");
    a_fault_tone: assert property (@(posedge clk) disable iff (!rst_b)
        any_fail && !q.ctrl[`CTRL_BUZ_DIS] |-> buzzer)
        else $error("fault tone not steady");
    a_alarm_tone: assert property (@(posedge clk) disable iff (!rst_b)
        !any_fail && bz == '0 |-> !buzzer)
        else $error("buzzer sounding with no event");
    a_write_lands: assert property (@(posedge clk) disable iff (!rst_b)
        wr && paddr == `OFF_CTRL |=> q.ctrl == $past(pwdata))
        else $error("control write did not land");

    a_relay_fail: assert property (@(posedge clk) disable iff (!rst_b)
        q.relmap[2][NE+2] && any_fail |-> alarm_relay[2])
        else $error("failure mapped relay not driven");
    a_relay_over: assert property (@(posedge clk) disable iff (!rst_b)
        q.relmap[2][NE] && |ovr |-> alarm_relay[2])
        else $error("over-range mapped relay not driven");
    a_relay_under: assert property (@(posedge clk) disable iff (!rst_b)
        q.relmap[2][NE+1] && |und |-> alarm_relay[2])
        else $error("under-range mapped relay not driven");
    a_nam_latch: assert property (@(posedge clk) disable iff (!rst_b)
        ce && q.flam[0] && ovr[0] |=> no_ambiguity_alarm[0])
        else $error("no-ambiguity alarm not latched");
    a_nam_fail: assert property (@(posedge clk) disable iff (!rst_b)
        |q.nam |-> !fault_relay)
        else $error("no-ambiguity alarm left fault relay on");

    a_count_limit: assert property (@(posedge clk) disable iff (!rst_b)
        !q.ctrl[`CTRL_LINES] && mod_cnt > 6'd5 |-> cfg_err)
        else $error("too many modules on one line accepted");
    a_two_line: assert property (@(posedge clk) disable iff (!rst_b)
        q.ctrl[`CTRL_LINES] && !q.ctrl[`CTRL_BRIDGE] && mod_cnt <= 6'd10
        && span_cnt <= `MOD_ADDR_MAX |-> !cfg_err)
        else $error("legal two-line module count refused");
    a_zone_steady: assert property (@(posedge clk) disable iff (!rst_b)
        ion[0] && !iblk[0] |-> zone_ind_on[0])
        else $error("steady zone lamp missing");
    a_zone_blink: assert property (@(posedge clk) disable iff (!rst_b)
        iblk[0] |-> zone_ind_blink[0])
        else $error("blinking zone lamp missing");
endmodule : gas_alarm_ack_manager
`default_nettype wire

// ==== verif/operator_side_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module operator_side_model #(
    parameter int HOLD = 3
) (
    input wire logic clk,
    input wire logic press,
    output logic reset_key
);
    int left = 0;
    // a press is a level held for several cycles, not a one-cycle pulse
    always @(posedge clk) begin
        if (press) begin
            left <= HOLD;
            reset_key <= 1'b1;
        end else if (left > 1) begin
            left <= left - 1;
        end else begin
            left <= 0;
            reset_key <= 1'b0;
        end
    end
    // switch bank of one module: address, frame filling off, delay on
    function automatic logic [7:0] bank(input logic [5:0] a, input logic last);
        bank = {last, 1'b1, 1'b0, a[4:0]};
    endfunction : bank
    // all five address switches off selects the top address
    function automatic logic [5:0] addr_of(input logic [7:0] sw);
        addr_of = (sw[4:0] == 5'h00) ? 6'h20 : {1'b0, sw[4:0]};
    endfunction : addr_of
endmodule : operator_side_model
`default_nettype wire

// ==== verif/tb.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "gas_alarm_defines.svh"
module tb;
    logic clk = 0, rst_b = 0, ce = 1, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, mask;
    logic pready, pslverr, reset_key, press = 0, fault_relay, buzzer;
    logic [3:0] det_fail = 4'h0, alarm_relay, over_a, under_a, noamb_a;
    logic [2:0] zone_ind_on, zone_ind_blink;
    int failures = 0, samples_checked = 0, cycles = 0;
    always #20 clk = ~clk;
    gas_alarm_ack_manager i_gas_alarm_ack_manager (.clk(clk), .rst_b(rst_b),
        .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .reset_key(reset_key), .det_fail(det_fail),
        .fault_relay(fault_relay), .buzzer(buzzer),
        .alarm_relay(alarm_relay), .over_range_alarm(over_a),
        .under_range_alarm(under_a), .no_ambiguity_alarm(noamb_a),
        .zone_ind_on(zone_ind_on), .zone_ind_blink(zone_ind_blink));
    operator_side_model i_operator_side_model (.clk(clk), .press(press),
        .reset_key(reset_key));
    task chk(input string what, input logic [31:0] exp,
        input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            failures++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) failures++;
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task settle;
        repeat (10) @(posedge clk);
    endtask : settle
    task meas(input logic [11:0] m);
        apb(1'b1, `OFF_MEAS_BASE, {20'h0, m});
        settle;
    endtask : meas
    task key_press;
        @(posedge clk);
        press <= 1'b1;
        @(posedge clk);
        press <= 1'b0;
        repeat (10) @(posedge clk);
    endtask : key_press
    task lamps(input logic [3:0] rel, input logic [2:0] on,
        input logic [2:0] bl);
        chk("alarm_relay", {28'h0, rel}, {28'h0, alarm_relay});
        chk("zone_ind_on", {29'h0, on}, {29'h0, zone_ind_on});
        chk("zone_ind_blink", {29'h0, bl}, {29'h0, zone_ind_blink});
    endtask : lamps
    task t_reset;
        chk("fault_relay", 32'h1, {31'h0, fault_relay});
        lamps(4'h0, 3'h0, 3'h0);
        apb(1'b0, `OFF_CTRL, 32'h0);
        chk("ctrl", `CTRL_RESET, rd);
        apb(1'b0, `OFF_LVL_BASE, 32'h0);
        chk("level cfg", `LVL_RESET, rd);
        apb(1'b0, 12'hffc, 32'h0);
        chk("unmapped", 32'h0, rd);
        $display("test reset done");
    endtask : t_reset
    task t_fault;
        det_fail <= 4'h2;
        settle;
        chk("fault_relay", 32'h0, {31'h0, fault_relay});
        chk("buzzer", 32'h1, {31'h0, buzzer});
        settle;
        chk("buzzer", 32'h1, {31'h0, buzzer});
        apb(1'b1, `OFF_CTRL, 32'h1);
        settle;
        chk("buzzer", 32'h0, {31'h0, buzzer});
        apb(1'b1, `OFF_CTRL, 32'h0);
        det_fail <= 4'h0;
        settle;
        chk("fault_relay", 32'h1, {31'h0, fault_relay});
        $display("test fault done");
    endtask : t_fault
    task t_auto;
        apb(1'b1, `OFF_RELMAP_BASE, 32'h1);
        apb(1'b1, `OFF_RELMAP_BASE + 12'h4, 32'h8000_0001);
        apb(1'b1, `OFF_LVL_BASE, 32'h0002_0100);
        meas(12'h200);
        lamps(4'h3, 3'h1, 3'h0);
        key_press;
        lamps(4'h1, 3'h1, 3'h0);
        meas(12'h000);
        lamps(4'h0, 3'h0, 3'h0);
        $display("test auto done");
    endtask : t_auto
    task t_manual;
        apb(1'b1, `OFF_LVL_BASE, 32'h0022_0100);
        meas(12'h200);
        lamps(4'h3, 3'h0, 3'h1);
        meas(12'h000);
        lamps(4'h3, 3'h0, 3'h1);
        key_press;
        lamps(4'h0, 3'h0, 3'h0);
        meas(12'h200);
        key_press;
        lamps(4'h1, 3'h1, 3'h0);
        meas(12'h000);
        lamps(4'h0, 3'h0, 3'h0);
        $display("test manual done");
    endtask : t_manual
    task t_levels;
        apb(1'b1, `OFF_LVL_BASE, 32'h000a_0100);
        meas(12'h110);
        lamps(4'h3, 3'h1, 3'h0);
        meas(12'h0ff);
        lamps(4'h3, 3'h1, 3'h0);
        meas(12'h0d0);
        lamps(4'h0, 3'h0, 3'h0);
        chk("buzzer", 32'h1, {31'h0, buzzer});
        key_press;
        chk("buzzer", 32'h0, {31'h0, buzzer});
        apb(1'b1, `OFF_LVL_BASE, 32'h0003_0100);
        meas(12'h050);
        lamps(4'h3, 3'h1, 3'h0);
        meas(12'h200);
        lamps(4'h0, 3'h0, 3'h0);
        $display("test levels done");
    endtask : t_levels
    task t_range;
        apb(1'b1, `OFF_LVL_BASE, `LVL_RESET);
        apb(1'b1, `OFF_RELMAP_BASE + 12'h8, 32'h7000);
        apb(1'b1, `OFF_UNDER_BASE, 32'h100);
        meas(12'h050);
        chk("under", 32'hf, {28'h0, under_a});
        chk("relay2", 32'h1, {31'h0, alarm_relay[2]});
        meas(12'h200);
        chk("under", 32'he, {28'h0, under_a});
        meas(`FULL_SCALE);
        key_press;
        chk("over", 32'h1, {28'h0, over_a});
        chk("relay2", 32'h1, {31'h0, alarm_relay[2]});
        meas(12'h200);
        chk("over", 32'h0, {28'h0, over_a});
        apb(1'b1, `OFF_MEAS_BASE, 32'h8000_0fff);
        settle;
        chk("noamb", 32'h1, {28'h0, noamb_a});
        chk("fault_relay", 32'h0, {31'h0, fault_relay});
        meas(12'h200);
        chk("noamb", 32'h0, {28'h0, noamb_a});
        $display("test range done");
    endtask : t_range
    task modules(input int n, input logic [31:0] ctrl, input logic err);
        mask = 32'h0;
        for (int i = 0; i < n; i++)
            mask[i_operator_side_model.addr_of(i_operator_side_model.bank(
                6'(i == 0 ? 0 : i + 1), i == n - 1)) - 1] = 1'b1;
        apb(1'b1, `OFF_CTRL, ctrl);
        apb(1'b1, `OFF_MODULE, mask);
        settle;
        apb(1'b0, `OFF_STATUS, 32'h0);
        chk("config error", {31'h0, err}, {31'h0, rd[14]});
    endtask : modules
    task t_modules;
        modules(6, 32'h0, 1'b1);
        modules(5, 32'h0, 1'b0);
        modules(6, 32'h2, 1'b0);
        modules(11, 32'h2, 1'b1);
        modules(1, 32'h4, 1'b1);
        $display("test modules done");
    endtask : t_modules
    task give_verdict;
        $display("checks %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // ceiling is roughly forty times the cycles the tests need
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            give_verdict;
        end
    end
    initial begin
        repeat (12) @(posedge clk);
        rst_b <= 1'b1;
        t_reset;
        t_fault;
        t_auto;
        t_manual;
        t_levels;
        t_range;
        t_modules;
        give_verdict;
    end
endmodule : tb
`default_nettype wire
